// File: hdl/pwm_dac_pkg.sv
package pwm_dac_pkg;

    // ==========================================================
    // code space
    localparam int            CODE_W    = 6;
    localparam int            SLOTS     = 64;
    localparam logic [5:0]    ZERO_CODE = 6'h00;
    localparam logic [5:0]    MAX_CODE  = 6'h3f;
    localparam logic [5:0]    MID_CODE  = 6'h20;

    // ==========================================================
    // timing
    localparam longint        CLK_HZ          = 200_000_000;
    localparam longint        PWM_FREQ_HZ     = 5_000;
    localparam longint        SLOT_CYCLES     = CLK_HZ / (PWM_FREQ_HZ * SLOTS);
    localparam int            PRESC_W         = 10;
    localparam logic [9:0]    PRESC_LAST      = 10'(SLOT_CYCLES - 1);
    localparam longint        DEBOUNCE_US     = 12_800;
    localparam longint        HOLD_DELAY_US   = 410_000;
    localparam longint        REPEAT_MILLI_HZ = 19_500;
    localparam longint        DEBOUNCE_CYC    = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam longint        HOLD_DELAY_CYC  = (CLK_HZ / 1_000_000) * HOLD_DELAY_US;
    localparam longint        REPEAT_CYC      = (CLK_HZ * 1_000) / REPEAT_MILLI_HZ;
    localparam logic [1:0]    MODE_SETTLE_LAST = 2'h2;

    // ==========================================================
    // reset values
    localparam logic [31:0]   TIMER_RST = 32'h0000_0000;
    localparam logic [1:0]    SETTLE_RST = 2'h0;

    // ==========================================================
    // types
    typedef enum logic {
        MODE_PULSE  = 1'b0,
        MODE_BUTTON = 1'b1
    } ifMode_t;

    typedef enum logic [1:0] {
        PRESS_NONE = 2'b00,
        PRESS_UP   = 2'b01,
        PRESS_DOWN = 2'b10
    } press_t;

    typedef enum logic [1:0] {
        BTN_IDLE     = 2'b00,
        BTN_DEBOUNCE = 2'b01,
        BTN_HOLD     = 2'b10,
        BTN_REPEAT   = 2'b11
    } btnState_t;

endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;

    // ==========================================================
    // two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            hold_ff <= '0;
        end else begin
            meta_ff <= d;
            hold_ff <= meta_ff;
        end
    end

    assign q = hold_ff;

endmodule

`default_nettype wire

// File: hdl/dual_pwm_dac.sv
// Contract
// (R1) two independent counters; step input A drives output A, B drives B
// (R2) 6-bit code gives 64 equal duty steps, code zero is 0% duty
// (R3) code 63 gives the largest duty cycle, 63/64 of a period
// (R4) pwm period comes from the internal clock and stays above 3 kHz
// (R5) on power-up both counters reset so outputs start at midscale
// (R6) midscale power-up code is 32
// (R7) both step inputs floating at power-up selects pushbutton mode until reset
// (R8) either step input at a logic level at power-up selects pulse mode
// (R9) pulse mode: each pulse adds one, wrapping from 63 to 0
// (R10) pushbutton: high press counts up to 63, low press down to 0, no wrap
// (R11) pushbutton: 12.8 ms debounce, after 410 ms hold repeat at 19.5 Hz
// (R12) low sleep input puts both pwm outputs in high impedance
// (R13) counts are kept through sleep and resume unchanged afterwards
// (R14) step inputs pass a synchroniser before any edge or level logic
`timescale 1ns/100ps
`default_nettype none

module dual_pwm_dac
    import pwm_dac_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = 32'(DEBOUNCE_CYC),
    parameter int unsigned HOLD_CYCLES     = 32'(HOLD_DELAY_CYC),
    parameter int unsigned REPEAT_CYCLES   = 32'(REPEAT_CYC)
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic chanAStepIn,
    input  wire logic chanAStepFloat,
    input  wire logic chanBStepIn,
    input  wire logic chanBStepFloat,
    input  wire logic sleepN,
    output logic      chanAPwmOut,
    output logic      chanAPwmOe,
    output logic      chanBPwmOut,
    output logic      chanBPwmOe,
    output logic      buttonMode
);

    // ==========================================================
    // input synchronisation
    logic [4:0] pinSync;
    logic [1:0] stepSync;
    logic [1:0] floatSync;
    logic       awakeSync;

    // all pins are asynchronous to clk
    pin_sync #(
        .W (5)
    ) u_pin_sync (
        .clk (clk),
        .rst (rst),
        .d   ({sleepN, chanBStepFloat, chanAStepFloat, chanBStepIn, chanAStepIn}),
        .q   (pinSync)
    ); // R14

    assign stepSync  = pinSync[1:0];
    assign floatSync = pinSync[3:2];
    assign awakeSync = pinSync[4];

    // ==========================================================
    // interface mode sensing
    logic [1:0] settle_ff;
    logic [1:0] nxt_settle;
    logic       modeValid_ff;
    logic       nxt_modeValid;
    ifMode_t    mode_ff;
    ifMode_t    nxt_mode;

    // wait for the synchroniser to fill before sampling the pins once
    always_comb begin
        nxt_settle    = settle_ff;
        nxt_modeValid = modeValid_ff;
        nxt_mode      = mode_ff;
        if (!modeValid_ff) begin
            if (settle_ff == MODE_SETTLE_LAST) begin
                nxt_modeValid = 1'b1;
                if (floatSync[0] && floatSync[1]) begin
                    nxt_mode = MODE_BUTTON; // R7
                end else begin
                    nxt_mode = MODE_PULSE; // R8
                end
            end else begin
                nxt_settle = settle_ff + 2'h1;
            end
        end
    end

    // mode is only re-sensed by a full reset
    always_ff @(posedge clk) begin
        if (rst) begin
            settle_ff    <= SETTLE_RST;
            modeValid_ff <= 1'b0;
            mode_ff      <= MODE_PULSE;
        end else begin
            settle_ff    <= nxt_settle;
            modeValid_ff <= nxt_modeValid;
            mode_ff      <= nxt_mode;
        end
    end

    assign buttonMode = (mode_ff == MODE_BUTTON);

    // ==========================================================
    // channel counters
    logic      [5:0]  code_ff     [2];
    logic      [5:0]  nxt_code    [2];
    btnState_t        state_ff    [2];
    btnState_t        nxt_state   [2];
    logic      [31:0] timer_ff    [2];
    logic      [31:0] nxt_timer   [2];
    press_t           press_ff    [2];
    press_t           nxt_press   [2];
    logic      [1:0]  stepPrev_ff;
    logic      [1:0]  nxt_stepPrev;
    logic             counting;

    // saturating one-step move in the pressed direction
    function automatic logic [5:0] satStep(input logic [5:0] c, input press_t p);
        logic [5:0] r;
        r = c;
        if (p == PRESS_UP && c != MAX_CODE) begin
            r = c + 6'h01;
        end else if (p == PRESS_DOWN && c != ZERO_CODE) begin
            r = c - 6'h01;
        end
        return r;
    endfunction

    // counting stops while asleep, so the codes are held untouched
    assign counting = modeValid_ff && awakeSync; // R13

    always_comb begin
        press_t pr;
        pr           = PRESS_NONE;
        nxt_stepPrev = stepSync;
        for (int i = 0; i < 2; i++) begin
            nxt_code[i]  = code_ff[i];
            nxt_state[i] = state_ff[i];
            nxt_timer[i] = timer_ff[i];
            nxt_press[i] = press_ff[i];
            // floating pin means no button is pressed
            if (floatSync[i]) begin
                pr = PRESS_NONE;
            end else if (stepSync[i]) begin
                pr = PRESS_UP;
            end else begin
                pr = PRESS_DOWN;
            end
            if (!counting) begin
                nxt_state[i] = BTN_IDLE;
                nxt_timer[i] = TIMER_RST;
                nxt_press[i] = PRESS_NONE;
            end else if (mode_ff == MODE_PULSE) begin
                // rising edge only; natural 6-bit overflow gives the wrap
                if (stepSync[i] && !stepPrev_ff[i]) begin
                    nxt_code[i] = code_ff[i] + 6'h01; // R9
                end
            end else if (pr != press_ff[i]) begin
                // any change to a pressed level restarts the debounce window; release goes idle
                nxt_press[i] = pr;
                nxt_timer[i] = TIMER_RST;
                nxt_state[i] = (pr == PRESS_NONE) ? BTN_IDLE : BTN_DEBOUNCE; // R11
            end else begin
                case (state_ff[i])
                    BTN_IDLE: begin
                        nxt_timer[i] = TIMER_RST;
                    end
                    BTN_DEBOUNCE: begin
                        if (timer_ff[i] == DEBOUNCE_CYCLES - 32'd1) begin
                            nxt_code[i]  = satStep(code_ff[i], pr); // R10
                            nxt_state[i] = BTN_HOLD;
                            nxt_timer[i] = TIMER_RST;
                        end else begin
                            nxt_timer[i] = timer_ff[i] + 32'd1; // R11
                        end
                    end
                    BTN_HOLD: begin
                        if (timer_ff[i] == HOLD_CYCLES - 32'd1) begin
                            nxt_code[i]  = satStep(code_ff[i], pr); // R10
                            nxt_state[i] = BTN_REPEAT;
                            nxt_timer[i] = TIMER_RST;
                        end else begin
                            nxt_timer[i] = timer_ff[i] + 32'd1; // R11
                        end
                    end
                    BTN_REPEAT: begin
                        if (timer_ff[i] == REPEAT_CYCLES - 32'd1) begin
                            nxt_code[i]  = satStep(code_ff[i], pr); // R10
                            nxt_timer[i] = TIMER_RST;
                        end else begin
                            nxt_timer[i] = timer_ff[i] + 32'd1; // R11
                        end
                    end
                    default: begin
                        nxt_state[i] = BTN_IDLE;
                        nxt_timer[i] = TIMER_RST;
                    end
                endcase
            end
        end
    end

    // each channel keeps its own counter and timer
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                code_ff[i]  <= MID_CODE; // R5 R6
                state_ff[i] <= BTN_IDLE;
                timer_ff[i] <= TIMER_RST;
                press_ff[i] <= PRESS_NONE;
            end
            stepPrev_ff <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                code_ff[i]  <= nxt_code[i]; // R1
                state_ff[i] <= nxt_state[i];
                timer_ff[i] <= nxt_timer[i];
                press_ff[i] <= nxt_press[i];
            end
            stepPrev_ff <= nxt_stepPrev;
        end
    end

    // ==========================================================
    // pwm timebase
    logic [9:0] presc_ff;
    logic [9:0] nxt_presc;
    logic [5:0] slot_ff;
    logic [5:0] nxt_slot;

    // 625 clocks per slot, 64 slots: 5 kHz from clk alone
    always_comb begin
        nxt_presc = presc_ff + 10'h001;
        nxt_slot  = slot_ff;
        if (presc_ff == PRESC_LAST) begin
            nxt_presc = 10'h000;
            nxt_slot  = slot_ff + 6'h01; // R4
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            presc_ff <= 10'h000;
            slot_ff  <= 6'h00;
        end else begin
            presc_ff <= nxt_presc;
            slot_ff  <= nxt_slot;
        end
    end

    // ==========================================================
    // pwm outputs
    logic [1:0] pwm_ff;
    logic [1:0] nxt_pwm;
    logic [1:0] oe_ff;
    logic [1:0] nxt_oe;

    // high for code slots out of 64; code 63 leaves one slot low
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            nxt_pwm[i] = awakeSync && (slot_ff < code_ff[i]); // R2 R3
            nxt_oe[i]  = awakeSync; // R12
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_ff <= 2'h0;
            oe_ff  <= 2'h0;
        end else begin
            pwm_ff <= nxt_pwm;
            oe_ff  <= nxt_oe;
        end
    end

    assign chanAPwmOut = pwm_ff[0]; // R1
    assign chanAPwmOe  = oe_ff[0];
    assign chanBPwmOut = pwm_ff[1];
    assign chanBPwmOe  = oe_ff[1];

endmodule

`default_nettype wire

// File: verif/dual_pwm_dac_props.sv
`timescale 1ns/100ps
`default_nettype none
// =====
// port checker
module dual_pwm_dac_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic chanAStepFloat,
    input wire logic chanBStepFloat,
    input wire logic sleepN,
    input wire logic chanAPwmOut,
    input wire logic chanAPwmOe,
    input wire logic chanBPwmOut,
    input wire logic chanBPwmOe,
    input wire logic buttonMode
);
    localparam int PERIOD = 40000;
    logic [16:0] gapCnt_ff;
    logic [16:0] hiCnt_ff;
    logic [3:0]  since_ff;
    logic        prevA_ff;
    logic        seen_ff;
    logic        riseA;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    assign riseA = chanAPwmOut && !prevA_ff;
    // period phase since reset and high-run length of channel a; the phase wraps each period
    // a rise after sleep may land mid-period, so sleep forgets the first rise
    always_ff @(posedge clk) begin
        if (rst) begin
            gapCnt_ff <= 17'h0;
            hiCnt_ff  <= 17'h0;
            since_ff  <= 4'h0;
            prevA_ff  <= 1'b0;
            seen_ff   <= 1'b0;
        end else begin
            gapCnt_ff <= (gapCnt_ff == 17'(PERIOD - 1)) ? 17'h0 : gapCnt_ff + 17'h1;
            hiCnt_ff  <= chanAPwmOut ? hiCnt_ff + 17'h1 : 17'h0;
            since_ff  <= (since_ff == 4'hf) ? since_ff : since_ff + 4'h1;
            prevA_ff  <= chanAPwmOut;
            seen_ff   <= chanAPwmOe ? (seen_ff | riseA) : 1'b0;
        end
    end
    sequence asleep3; !sleepN [*3]; endsequence
    sequence awake4; sleepN [*4]; endsequence
    chk_sleep_hiz: assert property (asleep3 |=> !chanAPwmOe && !chanBPwmOe)
        else $error("pwm still driven in sleep");
    chk_wake_drive: assert property (awake4 |=> chanAPwmOe && chanBPwmOe)
        else $error("pwm not driven while awake");
    chk_hiz_quiet: assert property ((!chanAPwmOe -> !chanAPwmOut) && (!chanBPwmOe -> !chanBPwmOut))
        else $error("pwm data high while undriven");
    chk_reset_quiet: assert property ($fell(rst) |-> !chanAPwmOe && !chanBPwmOe && !buttonMode)
        else $error("outputs active out of reset");
    chk_mode_hold: assert property (since_ff > 4'h4 |-> $stable(buttonMode))
        else $error("interface mode changed after sensing");
    chk_mode_sense: assert property (since_ff == 4'h8 |-> buttonMode == (chanAStepFloat && chanBStepFloat))
        else $error("wrong interface mode sensed");
    chk_pwm_period: assert property (riseA && seen_ff |-> gapCnt_ff == 17'h1)
        else $error("pwm period length wrong");
    chk_duty_max: assert property (chanAPwmOut |-> hiCnt_ff < 17'd39375)
        else $error("pwm high beyond top code");
endmodule
bind dual_pwm_dac dual_pwm_dac_props props (.clk(clk), .rst(rst), .chanAStepFloat(chanAStepFloat),
    .chanBStepFloat(chanBStepFloat), .sleepN(sleepN), .chanAPwmOut(chanAPwmOut),
    .chanAPwmOe(chanAPwmOe), .chanBPwmOut(chanBPwmOut), .chanBPwmOe(chanBPwmOe),
    .buttonMode(buttonMode));
`default_nettype wire

// File: verif/step_source.sv
`timescale 1ns/100ps
`default_nettype none
// =====
// one step pin: cmos pulses or a pushbutton
module step_source (
    input  wire logic clk,
    output wire logic pin,
    output var logic  floating
);
    logic level;
    logic noise;
    initial begin
        level = 1'b0;
        noise = 1'b0;
        floating = 1'b0;
    end
    // an open pin reads as noise, never as its last level
    assign pin = floating ? noise : level;
    always @(posedge clk) begin
        noise <= ~noise;
    end
    // hold the pin low or leave it open
    task automatic park(input logic f);
        @(posedge clk);
        floating <= f;
        level <= 1'b0;
    endtask
    // each pulse high 2 and low 3 cycles, above the sampling minimum
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            level <= 1'b1;
            repeat (2) @(posedge clk);
            level <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    // press for cyc cycles, then release for 4
    task automatic press(input logic up, input int cyc);
        @(posedge clk);
        level <= up;
        floating <= 1'b0;
        repeat (cyc) @(posedge clk);
        floating <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// File: verif/dual_pwm_dac_tb.sv
`timescale 1ns/100ps
`default_nettype none
// =====
// self-checking bench
module dual_pwm_dac_tb;
    logic       clk;
    logic       rst;
    logic       sleepN;
    wire        aIn, aFl, bIn, bFl;
    logic       aOut, aOe, bOut, bOe, btn;
    int         n_fail;
    int         compares;
    int         seed;
    int         hiCnt [2];
    logic [1:0] prevOut;
    logic [1:0] outNow;
    int         expQ [2][$];
    dual_pwm_dac #(.DEBOUNCE_CYCLES(20), .HOLD_CYCLES(50), .REPEAT_CYCLES(30)) dut (
        .clk(clk), .rst(rst), .chanAStepIn(aIn), .chanAStepFloat(aFl),
        .chanBStepIn(bIn), .chanBStepFloat(bFl), .sleepN(sleepN),
        .chanAPwmOut(aOut), .chanAPwmOe(aOe), .chanBPwmOut(bOut),
        .chanBPwmOe(bOe), .buttonMode(btn));
    step_source srcA (.clk(clk), .pin(aIn), .floating(aFl));
    step_source srcB (.clk(clk), .pin(bIn), .floating(bFl));
    always #2.5 clk = ~clk;
    assign outNow = {bOut, aOut};
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic power_up();
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
    endtask
    // bounded wait until every noted pulse length was seen
    task automatic drain();
        int k;
        k = 0;
        while (expQ[0].size() + expQ[1].size() > 0 && k < 45000) begin
            @(posedge clk);
            k++;
        end
        if (k == 45000) n_fail++;
    endtask
    // high time per pulse against the oldest note; pulses with no note pass by
    always @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (rst) hiCnt[c] = 0;
            else if (outNow[c] === 1'b1) hiCnt[c] = hiCnt[c] + 1;
            else if (prevOut[c] === 1'b1) begin
                if (expQ[c].size() > 0) check(hiCnt[c], expQ[c].pop_front());
                hiCnt[c] = 0;
            end
        end
        prevOut = outNow;
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        end_sim();
    end
    // pulse mode, sleep, wrap, one-floating sense, then pushbutton mode
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sleepN = 1'b1;
        seed = 32'hdd52b1af;
        n_fail = 0;
        compares = 0;
        prevOut = 2'h0;
        // first period after reset is two cycles short: the wake pin crosses its synchroniser
        expQ[0].push_back(19998);
        expQ[1].push_back(19998);
        power_up();
        check(btn, 1'b0);
        // codes move in the last slot, then sleep must keep them
        repeat (39430) @(posedge clk);
        fork
            srcA.pulses(40);
            srcB.pulses(33);
        join
        sleepN <= 1'b0;
        srcA.pulses(1 + ($unsigned($random(seed)) % 4));
        #1 check({aOe, bOe, aOut, bOut}, 4'h0);
        @(posedge clk);
        sleepN <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check({aOe, bOe}, 2'h3);
        expQ[0].push_back(5000);
        expQ[1].push_back(625);
        drain();
        srcA.park(1'b1);
        power_up();
        check(btn, 1'b0);
        srcB.park(1'b1);
        power_up();
        check(btn, 1'b1);
        // judged in the first period, again two synchroniser cycles short
        expQ[0].push_back(39373);
        expQ[1].push_back(18123);
        fork
            srcA.press(1'b1, 1200);
            begin
                srcB.press(1'b0, 2 + ($unsigned($random(seed)) % 10));
                srcB.press(1'b0, 115);
            end
        join
        drain();
        end_sim();
    end
endmodule
`default_nettype wire
